// ---- inc/psau_pkg.sv ----
// Purpose: shared constants and types for the program space access unit
// Assumes: 16-bit data path, 24-bit program space, APB register port
// Notes:   every offset, field position and cycle count lives here
package psau_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PA_W    = 24;
  localparam int unsigned RA_W    = 23;
  localparam int unsigned DA_W    = 16;
  localparam int unsigned PAGE_W  = 8;
  localparam int unsigned LOW_W   = 15;
  localparam int unsigned APB_AW  = 12;
  localparam int unsigned APB_DW  = 32;

  // ----------------------------------------------------------------
  // register offsets, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_TABLE_PAGE = 12'h000;
  localparam logic [11:0] OFF_REMAP_PAGE = 12'h004;
  localparam logic [11:0] OFF_CPU_CTRL   = 12'h008;
  localparam logic [11:0] OFF_STATUS     = 12'h00C;
  localparam int unsigned CTRL_REMAP_EN  = 2;
  localparam int unsigned TBL_CFG_BIT    = 7;
  localparam int unsigned EA_REMAP_BIT   = 15;
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_REFUSED     = 1;
  localparam int unsigned ST_REMAP       = 2;
  localparam logic [7:0]  RST_PAGE       = 8'h00;
  localparam logic [7:0]  REMAP_PROG     = 8'h00;
  localparam logic [7:0]  REMAP_EE       = 8'hFF;
  localparam logic [7:0]  EE_TBL_PAGE    = 8'h7F;
  localparam logic [23:0] CFG_IMPL_LO    = 24'hFF_0000;
  localparam logic [23:0] CFG_IMPL_HI    = 24'hFF_0003;

  // ----------------------------------------------------------------
  // extra cycles for remapped reads
  // ----------------------------------------------------------------
  localparam logic [1:0]  EXTRA_MOVE     = 2'h1;
  localparam logic [1:0]  EXTRA_OTHER    = 2'h2;
  localparam logic [1:0]  EXTRA_RPT_EDGE = 2'h2;
  localparam logic [1:0]  EXTRA_RPT_MID  = 2'h0;

  typedef enum logic [2:0] {
    OP_TABLE_READ_LOW,
    OP_TABLE_READ_HIGH,
    OP_TABLE_WRITE_LOW,
    OP_TABLE_WRITE_HIGH,
    OP_DATA_READ
  } psau_op_e;

endpackage : psau_pkg

// ---- logic/psau_addr_former.sv ----
// Purpose: forms table and remap program addresses
// Assumes: page registers and effective address are stable this cycle
// Notes:   purely combinational
`timescale 1ns/10ps
module psau_addr_former (
  input  wire logic [7:0]  table_page,
  input  wire logic [7:0]  remap_page,
  input  wire logic [15:0] effective_address,
  output logic      [23:0] table_addr,
  output logic      [22:0] remap_addr,
  output logic             table_cfg
);

  // ----------------------------------------------------------------
  // address concatenation, no alignment check on purpose
  // ----------------------------------------------------------------
  assign table_addr = {table_page, effective_address};
  assign table_cfg  = table_page[psau_pkg::TBL_CFG_BIT];
  assign remap_addr = {remap_page, effective_address[psau_pkg::LOW_W-1:0]};

endmodule : psau_addr_former

// ---- logic/psau_read_steer.sv ----
// Purpose: steers a 24-bit program word onto the 16-bit data path
// Assumes: byte select is effective address bit 0
// Notes:   high byte lane above the upper program byte is the phantom byte
`timescale 1ns/10ps
module psau_read_steer (
  input  wire logic [23:0] prog_word,
  input  wire logic        high_space,
  input  wire logic        byte_mode,
  input  wire logic        byte_sel,
  output logic      [15:0] data
);

  logic [7:0] low_byte;
  logic [7:0] high_byte;

  // ----------------------------------------------------------------
  // lane selection
  // ----------------------------------------------------------------
  assign low_byte  = byte_sel ? prog_word[15:8] : prog_word[7:0];
  assign high_byte = byte_sel ? 8'h00 : prog_word[23:16];

  always_comb
  begin
    data = '0;
    if (!high_space && !byte_mode)
      data = prog_word[15:0];
    else if (!high_space)
      data = {8'h00, low_byte};
    else if (!byte_mode)
      data = {8'h00, prog_word[23:16]};
    else
      data = {8'h00, high_byte};
  end

endmodule : psau_read_steer

// ---- logic/psau_top.sv ----
// Purpose: program space access unit, table and remap paths
// Assumes: cpu, program memory and holding latches share pclk
// Notes:   memory read data is valid one cycle after mem_rd_en
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps

module psau_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 cpu_req,
  input  wire psau_pkg::psau_op_e   cpu_op,
  input  wire logic                 cpu_byte_mode,
  input  wire logic [15:0]          cpu_ea,
  input  wire logic [15:0]          cpu_wdata,
  input  wire logic                 cpu_move_word,
  input  wire logic                 cpu_in_repeat,
  input  wire logic                 cpu_rpt_first,
  input  wire logic                 cpu_rpt_last,
  input  wire logic                 cpu_rpt_irq_exit,
  input  wire logic                 cpu_rpt_reentry,
  output logic                      cpu_remap_hit,
  output logic                      cpu_busy,
  output logic                      cpu_done,
  output logic                      cpu_refused,
  output logic      [15:0]          cpu_rdata,
  output logic                      mem_rd_en,
  output logic      [23:0]          mem_addr,
  output logic                      mem_cfg,
  output logic                      mem_eeprom,
  input  wire logic [23:0]          mem_rdata,
  output logic                      latch_wr_en,
  output logic      [23:0]          latch_addr,
  output logic      [15:0]          latch_wdata,
  output logic                      latch_high,
  output logic      [1:0]           latch_byte_en
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_FETCH,
    S_WAIT,
    S_HOLD,
    S_DONE
  } psau_state_e;

  psau_state_e        state;
  psau_state_e        next_state;
  psau_pkg::psau_op_e op_q;
  logic [7:0]         table_page_register;
  logic [7:0]         remap_page_register;
  logic               remap_en;
  logic               refused_sticky;
  logic               last_remap;
  logic               byte_q;
  logic               bsel_q;
  logic [1:0]         cnt;
  logic [23:0]        table_addr;
  logic [22:0]        remap_addr;
  logic               table_cfg;
  logic [15:0]        steer_data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // implemented configuration area, used by the request check only
  function automatic logic cfg_impl(input logic [23:0] a);
    cfg_impl = (a >= psau_pkg::CFG_IMPL_LO) && (a <= psau_pkg::CFG_IMPL_HI);
  endfunction : cfg_impl

  // extra cycles that a remapped read adds to the instruction
  function automatic logic [1:0] extra_cycles(input logic mv, input logic rpt, input logic edge_it);
    if (!rpt)
      extra_cycles = mv ? psau_pkg::EXTRA_MOVE : psau_pkg::EXTRA_OTHER;
    else
      extra_cycles = edge_it ? psau_pkg::EXTRA_RPT_EDGE : psau_pkg::EXTRA_RPT_MID;
  endfunction : extra_cycles

  // ----------------------------------------------------------------
  // address forming and read steering
  // ----------------------------------------------------------------
  psau_addr_former u_addr (
    .table_page        (table_page_register),
    .remap_page        (remap_page_register),
    .effective_address (cpu_ea),
    .table_addr        (table_addr),
    .remap_addr        (remap_addr),
    .table_cfg         (table_cfg)
  );

  psau_read_steer u_steer (
    .prog_word  (mem_rdata),
    .high_space (op_q == psau_pkg::OP_TABLE_READ_HIGH),
    .byte_mode  (byte_q),
    .byte_sel   (bsel_q),
    .data       (steer_data)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire take      = cpu_req && (state == S_IDLE);
  wire is_tbl_rd = (cpu_op == psau_pkg::OP_TABLE_READ_LOW) || (cpu_op == psau_pkg::OP_TABLE_READ_HIGH);
  wire is_tbl_wr = (cpu_op == psau_pkg::OP_TABLE_WRITE_LOW) || (cpu_op == psau_pkg::OP_TABLE_WRITE_HIGH);
  wire is_high   = (cpu_op == psau_pkg::OP_TABLE_READ_HIGH) || (cpu_op == psau_pkg::OP_TABLE_WRITE_HIGH);
  wire tbl_ee    = (table_page_register == psau_pkg::EE_TBL_PAGE);
  wire edge_it   = cpu_rpt_first || cpu_rpt_last || cpu_rpt_irq_exit || cpu_rpt_reentry;
  // table operations in flight block remap, so hit only counts in idle
  assign cpu_remap_hit = (cpu_op == psau_pkg::OP_DATA_READ) && cpu_ea[psau_pkg::EA_REMAP_BIT]
                         && remap_en && (state == S_IDLE);
  wire refuse    = (is_tbl_wr && table_cfg)
                   || (is_tbl_rd && table_cfg && !cfg_impl(table_addr))
                   || (is_high && tbl_ee);
  wire do_read   = take && ((is_tbl_rd && !refuse) || cpu_remap_hit);
  wire do_write  = take && is_tbl_wr && !refuse;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:  next_state = do_read ? S_FETCH : (take ? S_DONE : S_IDLE);
      S_FETCH: next_state = S_WAIT;
      S_WAIT:  next_state = (last_remap && cnt != 2'h0) ? S_HOLD : S_DONE;
      S_HOLD:  next_state = (cnt == 2'h1) ? S_DONE : S_HOLD;
      S_DONE:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // request capture, memory address and stretch count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q       <= psau_pkg::OP_TABLE_READ_LOW;
      byte_q     <= 1'b0;
      bsel_q     <= 1'b0;
      last_remap <= 1'b0;
      cnt        <= 2'h0;
      mem_addr   <= '0;
      mem_cfg    <= 1'b0;
      mem_eeprom <= 1'b0;
      cpu_refused <= 1'b0;
    end
    else if (take)
    begin
      op_q        <= cpu_op;
      byte_q      <= cpu_byte_mode;
      bsel_q      <= cpu_ea[0];
      last_remap  <= cpu_remap_hit;
      cnt         <= extra_cycles(cpu_move_word, cpu_in_repeat, edge_it);
      cpu_refused <= refuse && !cpu_remap_hit;
      mem_addr    <= cpu_remap_hit ? {1'b0, remap_addr} : table_addr;
      mem_cfg     <= cpu_remap_hit ? 1'b0 : table_cfg;
      mem_eeprom  <= cpu_remap_hit ? (remap_page_register == psau_pkg::REMAP_EE) : tbl_ee;
    end
    else if (state == S_HOLD)
      cnt <= cnt - 2'h1;
  end

  // read data lands from the steering path; remap keeps the low word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_rdata <= '0;
    else if (take)
      cpu_rdata <= '0;
    else if (state == S_WAIT)
      cpu_rdata <= last_remap ? mem_rdata[15:0] : steer_data;
  end

  // table writes only load the holding latches, never memory directly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_wr_en   <= 1'b0;
      latch_addr    <= '0;
      latch_wdata   <= '0;
      latch_high    <= 1'b0;
      latch_byte_en <= 2'h0;
    end
    else
    begin
      latch_wr_en <= do_write;
      if (do_write)
      begin
        latch_addr    <= table_addr;
        latch_wdata   <= cpu_wdata;
        latch_high    <= is_high;
        latch_byte_en <= cpu_byte_mode ? (cpu_ea[0] ? 2'h2 : 2'h1) : 2'h3;
      end
    end
  end

  assign mem_rd_en = (state == S_FETCH);
  assign cpu_busy  = (state != S_IDLE);
  assign cpu_done  = (state == S_DONE);

  // ----------------------------------------------------------------
  // apb register port
  // ----------------------------------------------------------------
  wire wr_acc  = psel && penable && pwrite;
  wire sel_tp  = (paddr == psau_pkg::OFF_TABLE_PAGE);
  wire sel_rp  = (paddr == psau_pkg::OFF_REMAP_PAGE);
  wire sel_cc  = (paddr == psau_pkg::OFF_CPU_CTRL);
  wire sel_st  = (paddr == psau_pkg::OFF_STATUS);
  wire hit     = sel_tp || sel_rp || sel_cc || sel_st;
  // remap page accepts only the two supported values, others are dropped
  wire rp_ok   = (pwdata[7:0] == psau_pkg::REMAP_PROG) || (pwdata[7:0] == psau_pkg::REMAP_EE);
  wire [31:0] status_word = {29'h0, last_remap, refused_sticky, cpu_busy};
  wire [31:0] rd_mux = sel_tp ? {24'h00_0000, table_page_register} :
                       sel_rp ? {24'h00_0000, remap_page_register} :
                       sel_cc ? {29'h0, remap_en, 2'h0} :
                       sel_st ? status_word : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      table_page_register <= psau_pkg::RST_PAGE;
      remap_page_register <= psau_pkg::RST_PAGE;
      remap_en            <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (sel_tp)
        table_page_register <= pwdata[7:0];
      if (sel_rp && rp_ok)
        remap_page_register <= pwdata[7:0];
      if (sel_cc)
        remap_en <= pwdata[psau_pkg::CTRL_REMAP_EN];
    end
  end

  // refused flag: a new refusal wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused_sticky <= 1'b0;
    else if (take && refuse && !cpu_remap_hit)
      refused_sticky <= 1'b1;
    else if (wr_acc && sel_st && pwdata[psau_pkg::ST_REFUSED])
      refused_sticky <= 1'b0;
  end

  // read data sampled in the setup phase so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_table_take;
    take && is_tbl_rd && !refuse && !cpu_remap_hit;
  endsequence

  sequence s_remap_take;
    take && cpu_remap_hit;
  endsequence

  AST_TABLE_ADDR: assert property (s_table_take |=> mem_addr == {$past(table_page_register), $past(cpu_ea)})
    else $error("table address not page over ea");
  AST_CFG_SPACE: assert property (s_table_take |=> mem_cfg == $past(table_page_register[psau_pkg::TBL_CFG_BIT]))
    else $error("config select not from page msb");
  AST_REMAP_ADDR: assert property (s_remap_take |=> !mem_cfg && mem_addr[14:0] == $past(cpu_ea[14:0])
                                   && mem_addr[22:15] == $past(remap_page_register))
    else $error("remap address wrong");
  AST_REMAP_GATE: assert property (take && cpu_op == psau_pkg::OP_DATA_READ
                                   && !(cpu_ea[psau_pkg::EA_REMAP_BIT] && remap_en)
                                   |=> !mem_rd_en && cpu_done)
    else $error("data read reached program space without ea msb and enable");
  AST_REMAP_PAGE: assert property (remap_page_register == psau_pkg::REMAP_PROG
                                   || remap_page_register == psau_pkg::REMAP_EE)
    else $error("remap page holds unsupported value");
  AST_CFG_NO_WRITE: assert property (take && is_tbl_wr && table_cfg |=> !latch_wr_en)
    else $error("table write reached latches in config space");
  AST_EE_HIGH: assert property (take && is_high && tbl_ee |=> !latch_wr_en && !mem_rd_en)
    else $error("high table op on eeprom not refused");
  AST_HIGH_ZERO: assert property (cpu_done && op_q == psau_pkg::OP_TABLE_READ_HIGH && !last_remap
                                  |-> cpu_rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  AST_SUSPEND: assert property (cpu_busy |-> !cpu_remap_hit)
    else $error("remap hit during table operation");
  AST_MOVE_STRETCH: assert property (s_remap_take and (!cpu_in_repeat && cpu_move_word)
                                     |-> !cpu_done [*4] ##1 cpu_done)
    else $error("move remap stretch not one cycle");
  AST_OTHER_STRETCH: assert property (s_remap_take and (!cpu_in_repeat && !cpu_move_word)
                                      |-> !cpu_done [*5] ##1 cpu_done)
    else $error("remap stretch not two cycles");
  AST_RPT_MID: assert property (s_remap_take and (cpu_in_repeat && !edge_it) |-> ##3 cpu_done)
    else $error("mid repeat remap not single cycle");
  AST_TABLE_TIME: assert property (s_table_take |-> ##1 mem_rd_en ##2 cpu_done)
    else $error("table read timing");

endmodule : psau_top

// ---- testbench/psau_mem_model.sv ----
// Purpose: program memory and data EEPROM as seen from the access unit
// Assumes: read data is wanted exactly one cycle after mem_rd_en
// Notes:   outside that cycle the lines toggle so stale data never passes
`timescale 1ns/10ps
module psau_mem_model #(
  parameter logic [23:0] WORD = 24'hFF_C396
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_rd_en,
  output logic      [23:0] mem_rdata
);
  // one word everywhere, so addresses are judged by the bench alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_rdata <= 24'h00_0000;
    else if (mem_rd_en)
      mem_rdata <= WORD;
    else
      mem_rdata <= ~mem_rdata; // never hold, a late sample must not pass
  end
endmodule : psau_mem_model

// ---- testbench/tb_program_space_access_unit.sv ----
// Purpose: self-checking bench for the program space access unit
// Assumes: memory answers one cycle after its read strobe
// Notes:   ordinary accesses run from a row table, reset and status by hand
`timescale 1ns/10ps
module tb_program_space_access_unit;
  // ctx is move, in repeat, first, last, irq exit, re-entry; lat is edges from take to done
  typedef struct packed {
    psau_pkg::psau_op_e op; logic bm; logic [15:0] ea; logic [7:0] tp; logic [7:0] rp; logic en;
    logic [5:0] ctx; logic [3:0] lat; logic [23:0] addr; logic [15:0] data; logic refd;
  } psau_row_s;
  localparam psau_pkg::psau_op_e RL = psau_pkg::OP_TABLE_READ_LOW;
  localparam psau_pkg::psau_op_e RH = psau_pkg::OP_TABLE_READ_HIGH;
  localparam psau_pkg::psau_op_e WL = psau_pkg::OP_TABLE_WRITE_LOW;
  localparam psau_pkg::psau_op_e WH = psau_pkg::OP_TABLE_WRITE_HIGH;
  localparam psau_pkg::psau_op_e DR = psau_pkg::OP_DATA_READ;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_req, cpu_byte_mode;
  logic               cpu_move_word, cpu_in_repeat, cpu_rpt_first, cpu_rpt_last, cpu_rpt_irq_exit;
  logic               cpu_rpt_reentry, cpu_remap_hit, cpu_busy, cpu_done, cpu_refused, mem_rd_en, mem_cfg;
  logic               mem_eeprom, latch_wr_en, latch_high, got_rd, got_wr, mc, me, lh, e;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  psau_pkg::psau_op_e cpu_op;
  logic [15:0]        cpu_ea, cpu_wdata, cpu_rdata, latch_wdata, lw;
  logic [23:0]        mem_addr, mem_rdata, latch_addr, ma, la;
  logic [1:0]         latch_byte_en, lb;
  int                 bad_count, tests_run, n;
  psau_row_s          rows [21];

  psau_top dut (.*);
  psau_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata));

  // 250 MHz
  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a bound that runs out counts as a mismatch and ends the run
  task automatic hang();
    bad_count++;
    give_verdict();
  endtask : hang

  // one APB transfer; an idle edge follows so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    {rd, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (k >= 50)
      hang();
    @(posedge pclk);
  endtask : apb

  // one cpu request; after the take the inputs turn into a remap candidate
  task automatic cpu(input psau_row_s r);
    n = 0;
    {got_rd, got_wr} = 2'h0;
    cpu_op <= r.op;
    {cpu_byte_mode, cpu_ea, cpu_wdata, cpu_req} <= {r.bm, r.ea, 16'hBEEF, 1'h1};
    {cpu_move_word, cpu_in_repeat, cpu_rpt_first, cpu_rpt_last, cpu_rpt_irq_exit, cpu_rpt_reentry} <= r.ctx;
    @(posedge pclk);
    cpu_op <= DR;
    {cpu_req, cpu_ea} <= {1'h0, 16'hFFFF};
    do
    begin
      @(posedge pclk);
      n++;
      if (mem_rd_en === 1'h1)
        {got_rd, ma, mc, me} = {1'h1, mem_addr, mem_cfg, mem_eeprom};
      if (latch_wr_en === 1'h1)
        {got_wr, la, lw, lh, lb} = {1'h1, latch_addr, latch_wdata, latch_high, latch_byte_en};
      chk(32'(cpu_busy), 32'h1);
      if (cpu_busy === 1'h1)
        chk(32'(cpu_remap_hit), 32'h0);
    end
    while (cpu_done !== 1'h1 && n < 20);
    if (n >= 20)
      hang();
  endtask : cpu

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cpu_req, cpu_byte_mode, cpu_ea, cpu_wdata} = '0;
    {cpu_move_word, cpu_in_repeat, cpu_rpt_first, cpu_rpt_last, cpu_rpt_irq_exit, cpu_rpt_reentry} = '0;
    cpu_op = DR;
    rows = '{
      '{RL, 1'h0, 16'h1235, 8'h12, 8'h00, 1'h1, 6'h00, 4'h3, 24'h12_1235, 16'hC396, 1'h0},
      '{RL, 1'h1, 16'h1235, 8'h12, 8'h00, 1'h1, 6'h00, 4'h3, 24'h12_1235, 16'h00C3, 1'h0},
      '{RL, 1'h1, 16'h1234, 8'h12, 8'h00, 1'h0, 6'h00, 4'h3, 24'h12_1234, 16'h0096, 1'h0},
      '{RH, 1'h0, 16'h1234, 8'h12, 8'h00, 1'h0, 6'h00, 4'h3, 24'h12_1234, 16'h00FF, 1'h0},
      '{RH, 1'h1, 16'h1234, 8'h12, 8'h00, 1'h0, 6'h00, 4'h3, 24'h12_1234, 16'h00FF, 1'h0},
      '{RH, 1'h1, 16'h1235, 8'h12, 8'h00, 1'h0, 6'h00, 4'h3, 24'h12_1235, 16'h0000, 1'h0},
      '{RL, 1'h0, 16'h0002, 8'hFF, 8'h00, 1'h0, 6'h00, 4'h3, 24'hFF_0002, 16'hC396, 1'h0},
      '{WL, 1'h0, 16'h0046, 8'h80, 8'h00, 1'h0, 6'h00, 4'h1, 24'h00_0000, 16'h0000, 1'h1},
      '{RH, 1'h0, 16'h0004, 8'h7F, 8'h00, 1'h0, 6'h00, 4'h1, 24'h00_0000, 16'h0000, 1'h1},
      '{RL, 1'h0, 16'h0004, 8'h7F, 8'h00, 1'h0, 6'h00, 4'h3, 24'h7F_0004, 16'hC396, 1'h0},
      '{WL, 1'h0, 16'h0046, 8'h12, 8'h00, 1'h0, 6'h00, 4'h1, 24'h12_0046, 16'h0000, 1'h0},
      '{WH, 1'h1, 16'h0047, 8'h12, 8'h00, 1'h0, 6'h00, 4'h1, 24'h12_0047, 16'h0000, 1'h0},
      '{DR, 1'h0, 16'h9234, 8'h00, 8'h00, 1'h1, 6'h20, 4'h4, 24'h00_1234, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'hFFFE, 8'h00, 8'hFF, 1'h1, 6'h00, 4'h5, 24'h7F_FFFE, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h8002, 8'h00, 8'h00, 1'h1, 6'h18, 4'h5, 24'h00_0002, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h8002, 8'h00, 8'h00, 1'h1, 6'h14, 4'h5, 24'h00_0002, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h8002, 8'h00, 8'h00, 1'h1, 6'h12, 4'h5, 24'h00_0002, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h8002, 8'h00, 8'h00, 1'h1, 6'h11, 4'h5, 24'h00_0002, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h8002, 8'h00, 8'h00, 1'h1, 6'h10, 4'h3, 24'h00_0002, 16'hC396, 1'h0},
      '{DR, 1'h0, 16'h9234, 8'h00, 8'h00, 1'h0, 6'h00, 4'h1, 24'h00_0000, 16'h0000, 1'h0},
      '{RL, 1'h0, 16'h0010, 8'hFF, 8'h00, 1'h0, 6'h00, 4'h1, 24'h00_0000, 16'h0000, 1'h1}
    };
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // reset values of the four words, then one unmapped word
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h0, 12'(i * 4), 32'h0000_0000);
      chk(rd | 32'(e), 32'(i == 4));
    end
    // only the two legal remap pages are kept
    apb(1'h1, psau_pkg::OFF_REMAP_PAGE, 32'h0000_00FF);
    apb(1'h1, psau_pkg::OFF_REMAP_PAGE, 32'h0000_0055);
    apb(1'h0, psau_pkg::OFF_REMAP_PAGE, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    foreach (rows[i])
    begin
      apb(1'h1, psau_pkg::OFF_TABLE_PAGE, {24'h00_0000, rows[i].tp});
      apb(1'h1, psau_pkg::OFF_REMAP_PAGE, {24'h00_0000, rows[i].rp});
      apb(1'h1, psau_pkg::OFF_CPU_CTRL, {29'h0000_0000, rows[i].en, 2'h0});
      cpu(rows[i]);
      chk(32'(n), 32'(rows[i].lat));
      chk(32'(cpu_rdata), 32'(rows[i].data));
      chk(32'(cpu_refused), 32'(rows[i].refd));
      chk(32'(got_rd), 32'(rows[i].op inside {RL, RH, DR} && rows[i].lat > 4'h1));
      if (got_rd === 1'h1)
        chk({7'h00, mc, ma}, {7'h00, rows[i].op != DR && rows[i].tp[7], rows[i].addr});
      if (got_rd === 1'h1)
        chk(32'(me), 32'(rows[i].op == DR ? rows[i].rp == 8'hFF : rows[i].tp == 8'h7F));
      chk(32'(got_wr), 32'(rows[i].op inside {WL, WH} && !rows[i].refd));
      if (got_wr === 1'h1)
        chk({lh, 7'h00, la}, {rows[i].op == WH, 7'h00, rows[i].addr});
      if (got_wr === 1'h1)
        chk(32'(lw), 32'h0000_BEEF);
      if (got_wr === 1'h1)
        chk(32'(lb), 32'(rows[i].bm ? (rows[i].ea[0] ? 2'h2 : 2'h1) : 2'h3));
    end
    // the last row was refused: sticky flag, then write-one clear
    apb(1'h0, psau_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    apb(1'h1, psau_pkg::OFF_STATUS, 32'h0000_0002);
    apb(1'h0, psau_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0000);
    // mid-run reset must bring the remap page back to its reset value
    apb(1'h1, psau_pkg::OFF_REMAP_PAGE, 32'h0000_00FF);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, psau_pkg::OFF_REMAP_PAGE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb_program_space_access_unit
